// >>> fpe_consts.vh
// constants for the flash program/erase control block
`ifndef FPE_CONSTS_VH
`define FPE_CONSTS_VH
// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define FPE_OFS_CTRL      12'h000
`define FPE_OFS_PROTECT   12'h004
`define FPE_OFS_STATUS    12'h008
`define FPE_OFS_TARGET    12'h00C
// ------------------------------------------------------------
// control field positions
// ------------------------------------------------------------
`define FPE_BIT_PROG      0
`define FPE_BIT_ERASE     1
`define FPE_BIT_MASS      2
`define FPE_BIT_HIVOLT    3
// ------------------------------------------------------------
// reset values and address layout
// ------------------------------------------------------------
`define FPE_CTRL_RST      4'h0
`define FPE_PROT_RST      8'hFF
`define FPE_ADDR_W        16
`define FPE_ARRAY_LO      16'hDC00
`define FPE_USER_HI       16'hFBFF
`define FPE_VECT_LO       16'hFFDC
`define FPE_VECT_HI       16'hFFFF
`define FPE_PROT_ALL      8'h70
`define FPE_PROT_NONE     8'hFF
`define FPE_PAGE_MASK     16'hFFC0
`define FPE_ROW_MASK      16'hFFE0
// ------------------------------------------------------------
// timing in nanoseconds and clock period
// ------------------------------------------------------------
`define FPE_CLK_NS        4
`define FPE_TNVS_NS       10000
`define FPE_TPGS_NS       5000
`endif

// >>> fpe_wait_timer.v
// one-shot cycle counter that reports when a least wait has elapsed
`timescale 1ns/1ps
module fpe_wait_timer #(
	parameter CNT_W = 12
)(
	input  wire             clk_sys,
	input  wire             rstn,
	input  wire             start,
	input  wire             clear,
	input  wire [CNT_W-1:0] loadCount,
	output reg              done
);
	reg [CNT_W-1:0] count_reg;
	reg             run_reg;

	// count down from the load value; done stays set until cleared or restarted
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			count_reg <= {CNT_W{1'b0}};
			run_reg   <= 1'b0;
			done      <= 1'b0;
		end
		else if (clear)
		begin
			run_reg <= 1'b0;
			done    <= 1'b0;
		end
		else if (start)
		begin
			count_reg <= loadCount;
			run_reg   <= 1'b1;
			done      <= 1'b0;
		end
		else if (run_reg)
		begin
			if (count_reg <= {{(CNT_W-1){1'b0}}, 1'b1})
			begin
				run_reg <= 1'b0;
				done    <= 1'b1;
			end
			else
				count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// >>> fpe_flash_ctrl.v
// flash program/erase sequencer with APB control registers
//
// What this block does
// - high voltage enable drives pump; settable only with a select and proper sequence
// - with erase selected, bulk bit 1 erases whole array, 0 one page
// - erase select and program select are never both 1
// - erased array bits read 1, programmed bits read 0
// - page erase clears exactly one 64-byte aligned page
// - user area plus a separate vector region handled as its own page
// - page erase aimed at vector region leaves it unchanged
// - programming works on 32-byte aligned rows
// - program select enables latching; high voltage waits setup before data
// - high voltage refused when the target lies in the protected range
// - protect byte gives address bits 13:6; 15:14 ones, 5:0 zeros
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module fpe_flash_ctrl #(
	parameter ADDR_W = 16
)(
	input  wire              clk_sys,
	input  wire              rstn,
	// apb slave
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [11:0]       paddr,
	input  wire [31:0]       pwdata,
	output reg               pready,
	output reg  [31:0]       prdata,
	output reg               pslverr,
	// array access port from the cpu side
	input  wire              arrayWrite,
	input  wire [ADDR_W-1:0] arrayAddr,
	input  wire [7:0]        arrayWdata,
	// array macro controls
	output reg               pumpOn,
	output reg               doProgram,
	output reg               doPageErase,
	output reg               doMassErase,
	output reg  [ADDR_W-1:0] opAddr,
	output reg  [7:0]        opData,
	output reg               opStrobe
);
`include "fpe_consts.vh"

	// ------------------------------------------------------------
	// timing counts
	// ------------------------------------------------------------
	localparam integer SETUP_INT = (`FPE_TNVS_NS + `FPE_CLK_NS - 1) / `FPE_CLK_NS;
	localparam integer PGS_INT   = (`FPE_TPGS_NS + `FPE_CLK_NS - 1) / `FPE_CLK_NS;
	// both counts stay below 4096, so the timer width holds them
	localparam [11:0]  SETUP_CYC = SETUP_INT[11:0];
	localparam [11:0]  PGS_CYC   = PGS_INT[11:0];

	// sequence states
	localparam [2:0] ST_IDLE  = 3'b000;
	localparam [2:0] ST_SEL   = 3'b001;
	localparam [2:0] ST_READ  = 3'b010;
	localparam [2:0] ST_LATCH = 3'b011;
	localparam [2:0] ST_HV    = 3'b100;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	reg              progSel_reg;
	reg              eraseSel_reg;
	reg              bulkSel_reg;
	reg              high_voltage_enable_reg;
	reg  [7:0]       protect_start_bits_reg;
	reg  [2:0]       state_reg;
	reg  [2:0]       state_next;
	reg  [ADDR_W-1:0] target_reg;
	reg              refused_reg;
	wire             setupDone;
	wire             pgsDone;

	wire apbWr = psel && penable && pwrite;
	wire apbRd = psel && penable && !pwrite;
	wire ctrlWr = apbWr && (paddr == `FPE_OFS_CTRL);

	// protected start address from the protect byte
	function [ADDR_W-1:0] protStart;
		input [7:0] bits;
		begin
			protStart = {2'b11, bits, 6'h00};
		end
	endfunction

	// whether an address falls in the protected range
	function isProtected;
		input [7:0]        bits;
		input [ADDR_W-1:0] addr;
		begin
			if (bits == `FPE_PROT_NONE)
				isProtected = 1'b0;
			else if (bits <= `FPE_PROT_ALL)
				isProtected = 1'b1;
			else
				isProtected = (addr >= protStart(bits));
		end
	endfunction

	function inArray;
		input [ADDR_W-1:0] addr;
		begin
			inArray = ((addr >= `FPE_ARRAY_LO) && (addr <= `FPE_USER_HI)) ||
				(addr >= `FPE_VECT_LO);
		end
	endfunction

	wire isVector = (target_reg >= `FPE_VECT_LO);
	wire anySel = progSel_reg || eraseSel_reg;
	// bulk erase checks the whole array; any protected range reaches the top address
	wire blocked = (eraseSel_reg && bulkSel_reg) ?
		isProtected(protect_start_bits_reg, `FPE_VECT_HI) :
		isProtected(protect_start_bits_reg, target_reg);
	wire wantHv = ctrlWr && pwdata[`FPE_BIT_HIVOLT];
	wire hvAllowed = anySel && (state_reg == ST_LATCH) && setupDone && !blocked;

	// ------------------------------------------------------------
	// setup timers
	// ------------------------------------------------------------
	fpe_wait_timer #(.CNT_W(12)) uSetup (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.start    (state_reg == ST_READ && arrayWrite && inArray(arrayAddr)),
		.clear    (!anySel),
		.loadCount(SETUP_CYC),
		.done     (setupDone)
	);

	fpe_wait_timer #(.CNT_W(12)) uPgs (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.start    (hvAllowed && wantHv && !high_voltage_enable_reg),
		.clear    (!high_voltage_enable_reg && !(hvAllowed && wantHv)),
		.loadCount(PGS_CYC),
		.done     (pgsDone)
	);

	// ------------------------------------------------------------
	// sequence tracker
	// ------------------------------------------------------------
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (anySel)
					state_next = ST_SEL;
			ST_SEL:
				if (!anySel)
					state_next = ST_IDLE;
				else if (apbRd && paddr == `FPE_OFS_PROTECT)
					state_next = ST_READ;
			ST_READ:
				if (!anySel)
					state_next = ST_IDLE;
				else if (arrayWrite && inArray(arrayAddr))
					state_next = ST_LATCH;
			ST_LATCH:
				if (!anySel)
					state_next = ST_IDLE;
				else if (high_voltage_enable_reg)
					state_next = ST_HV;
			ST_HV:
				if (!anySel && !high_voltage_enable_reg)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	// control bits with select interlock and guarded high voltage
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			{high_voltage_enable_reg, bulkSel_reg, eraseSel_reg, progSel_reg} <= `FPE_CTRL_RST;
			protect_start_bits_reg <= `FPE_PROT_RST;
		end
		else if (apbWr)
		begin
			if (paddr == `FPE_OFS_CTRL)
			begin
				bulkSel_reg <= pwdata[`FPE_BIT_MASS];
				// a set of one select is refused while the other is held
				if (pwdata[`FPE_BIT_ERASE] && pwdata[`FPE_BIT_PROG])
				begin
					eraseSel_reg <= eraseSel_reg;
					progSel_reg  <= progSel_reg;
				end
				else
				begin
					eraseSel_reg <= pwdata[`FPE_BIT_ERASE] && !progSel_reg;
					progSel_reg  <= pwdata[`FPE_BIT_PROG] && !eraseSel_reg;
				end
				if (!pwdata[`FPE_BIT_HIVOLT])
					high_voltage_enable_reg <= 1'b0;
				else if (hvAllowed || high_voltage_enable_reg)
					high_voltage_enable_reg <= 1'b1;
			end
			else if (paddr == `FPE_OFS_PROTECT)
				protect_start_bits_reg <= pwdata[7:0];
		end
	end

	// refused attempt to raise high voltage is sticky until next control register write
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			refused_reg <= 1'b0;
		else if (wantHv && !high_voltage_enable_reg && !hvAllowed)
			refused_reg <= 1'b1;
		else if (ctrlWr)
			refused_reg <= 1'b0;
	end

	// capture first in-array write address after the protect read that follows a select
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			target_reg <= {ADDR_W{1'b0}};
		else if (state_reg == ST_READ && arrayWrite && inArray(arrayAddr))
			target_reg <= arrayAddr;
	end

	// ------------------------------------------------------------
	// array macro drive
	// ------------------------------------------------------------
	// erase scope and data strobes toward the array
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			pumpOn      <= 1'b0;
			doProgram   <= 1'b0;
			doPageErase <= 1'b0;
			doMassErase <= 1'b0;
			opAddr      <= {ADDR_W{1'b0}};
			opData      <= 8'h00;
			opStrobe    <= 1'b0;
		end
		else
		begin
			pumpOn      <= high_voltage_enable_reg;
			doMassErase <= high_voltage_enable_reg && eraseSel_reg && bulkSel_reg;
			// page erase on a vector target does nothing
			doPageErase <= high_voltage_enable_reg && eraseSel_reg && !bulkSel_reg && !isVector;
			doProgram   <= high_voltage_enable_reg && progSel_reg;
			opStrobe    <= 1'b0;
			if (eraseSel_reg && !bulkSel_reg)
				opAddr <= target_reg & `FPE_PAGE_MASK;
			else if (progSel_reg && !(high_voltage_enable_reg && pgsDone))
				opAddr <= target_reg & `FPE_ROW_MASK;
			// byte writes in the captured row are passed on after the setup wait
			if (high_voltage_enable_reg && progSel_reg && pgsDone && arrayWrite &&
				((arrayAddr & `FPE_ROW_MASK) == (target_reg & `FPE_ROW_MASK)) &&
				!isProtected(protect_start_bits_reg, arrayAddr))
			begin
				opAddr   <= arrayAddr;
				opData   <= arrayWdata & 8'hFF; // data 0 bits program, 1 bits stay erased
				opStrobe <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	// single wait-free access; read data in access phase
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable)
			begin
				case (paddr)
					`FPE_OFS_CTRL:
						prdata <= {28'h0000000, high_voltage_enable_reg, bulkSel_reg, eraseSel_reg, progSel_reg};
					`FPE_OFS_PROTECT:
						prdata <= {24'h000000, protect_start_bits_reg};
					`FPE_OFS_STATUS:
						prdata <= {25'h0000000, refused_reg, pgsDone, setupDone, 1'b0, state_reg};
					`FPE_OFS_TARGET:
						prdata <= {16'h0000, target_reg};
					default:
						pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule

// >>> fpe_flash_ctrl_asserts.sv
// concurrent checks on the ports of the flash program/erase control block
`timescale 1ns/1ps
`include "fpe_consts.vh"
module fpe_flash_ctrl_asserts #(
	parameter ADDR_W = 16
)(
	input wire              clk_sys,
	input wire              rstn,
	input wire              psel,
	input wire              penable,
	input wire              pready,
	input wire              pslverr,
	input wire              arrayWrite,
	input wire [ADDR_W-1:0] arrayAddr,
	input wire [7:0]        arrayWdata,
	input wire              pumpOn,
	input wire              doProgram,
	input wire              doPageErase,
	input wire              doMassErase,
	input wire [ADDR_W-1:0] opAddr,
	input wire [7:0]        opData,
	input wire              opStrobe
);
	// all checks share the system clock and reset
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// -------------------------------------------
	// bus handshake
	// -------------------------------------------
	chk_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");

	// -------------------------------------------
	// array operation controls
	// -------------------------------------------
	chk_select_excl: assert property (doProgram |-> !(doPageErase || doMassErase))
		else $error("program and erase together");
	chk_scope_excl: assert property (doMassErase |-> !doPageErase)
		else $error("mass and page erase together");
	chk_page_align: assert property (doPageErase |-> opAddr[5:0] == 6'h00)
		else $error("page base not aligned");
	chk_vector_kept: assert property (doPageErase |-> opAddr <= `FPE_USER_HI)
		else $error("page erase hits vector region");
	chk_strobe_source: assert property (opStrobe |-> $past(arrayWrite) && pumpOn &&
		opAddr == $past(arrayAddr) && opData == $past(arrayWdata))
		else $error("program strobe not from array write");
	chk_reset_clear: assert property ($rose(rstn) |->
		!(pumpOn || doProgram || doPageErase || doMassErase || opStrobe))
		else $error("controls not clear after reset");

	cov_strobe: cover property (opStrobe);
	cov_page: cover property (doPageErase);
	cov_mass: cover property (doMassErase);
	cov_err: cover property (pslverr);
endmodule

// >>> test_flash_program_erase_control.sv
// self-checking testbench for the flash program/erase control block
`timescale 1ns/1ps
`include "fpe_consts.vh"
`define CK(g,e) begin totalChecks++; if ((g) !== (e)) begin numErrors++; \
	$display("FAIL t=%0t got %0h exp %0h", $time, g, e); end end
module test_flash_program_erase_control;
	reg        clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, arrayWrite = 0;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, rdat;
	reg [15:0] arrayAddr = 0;
	reg [7:0]  arrayWdata = 0;
	reg        rerr, seen;
	wire       pready, pslverr, pumpOn, doProgram, doPageErase, doMassErase, opStrobe;
	wire [31:0] prdata;
	wire [15:0] opAddr;
	wire [7:0]  opData;
	integer    numErrors = 0, totalChecks = 0;

	fpe_flash_ctrl DUT (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .arrayWrite(arrayWrite), .arrayAddr(arrayAddr),
		.arrayWdata(arrayWdata), .pumpOn(pumpOn), .doProgram(doProgram),
		.doPageErase(doPageErase), .doMassErase(doMassErase), .opAddr(opAddr),
		.opData(opData), .opStrobe(opStrobe));

	// 250 MHz system clock
	initial forever #2 clk_sys = ~clk_sys;

	// one apb transfer, held until ready is sampled at a rising edge, then one idle edge
	task apb(input w, input [11:0] a, input [31:0] d);
	begin
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdat = prdata; rerr = pslverr;
		psel <= 0; penable <= 0;
		@(posedge clk_sys);
	end
	endtask

	task rdc(input [11:0] a, input [31:0] m, input [31:0] e);
	begin
		apb(0, a, 0);
		`CK(rdat & m, e)
	end
	endtask

	// cpu write into the array; notes whether a program strobe followed
	task aw(input [15:0] a, input [7:0] d);
	begin
		arrayWrite <= 1; arrayAddr <= a; arrayWdata <= d;
		@(posedge clk_sys);
		arrayWrite <= 0; seen = 0;
		repeat (3) begin @(negedge clk_sys); seen = seen | opStrobe; end
		@(posedge clk_sys);
	end
	endtask

	// select, protect read, dummy write, setup wait, then ask for high voltage
	task arm(input [3:0] sel, input [15:0] a, input ok);
	begin
		apb(1, `FPE_OFS_CTRL, sel);
		apb(0, `FPE_OFS_PROTECT, 0);
		aw(a, 8'hFF);
		repeat (2510) @(posedge clk_sys);
		apb(1, `FPE_OFS_CTRL, sel | 4'h8);
		rdc(`FPE_OFS_CTRL, 32'h8, ok ? 32'h8 : 32'h0);
		repeat (3) @(posedge clk_sys);
	end
	endtask

	// release select first, then high voltage
	task drop;
	begin
		apb(1, `FPE_OFS_CTRL, 32'h8);
		apb(1, `FPE_OFS_CTRL, 32'h0);
		@(posedge clk_sys);
		`CK(pumpOn, 1'b0)
	end
	endtask

	task endOfTest;
	begin
		$display("checks %0d errors %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask

	// watchdog against a hung handshake
	initial
	begin
		#150000;
		numErrors++;
		endOfTest;
	end

	// main sequence
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rstn <= 1;
		@(posedge clk_sys);
		rdc(`FPE_OFS_CTRL, 32'hF, 32'h0);
		rdc(`FPE_OFS_PROTECT, 32'hFF, 32'hFF);
		apb(0, 12'h010, 0);
		`CK(rerr, 1'b1)
		apb(1, `FPE_OFS_CTRL, 32'h3);
		rdc(`FPE_OFS_CTRL, 32'h3, 32'h0);
		apb(1, `FPE_OFS_CTRL, 32'h8);
		rdc(`FPE_OFS_CTRL, 32'h8, 32'h0);
		rdc(`FPE_OFS_STATUS, 32'h40, 32'h40);
		$display("test registers done");
		arm(4'h2, 16'hE07F, 1);
		`CK({doPageErase, pumpOn, opAddr}, {2'b11, 16'hE040})
		drop;
		arm(4'h2, 16'hFFE5, 1);
		`CK(doPageErase, 1'b0)
		drop;
		$display("test page erase done");
		arm(4'h1, 16'hE123, 1);
		`CK(doProgram, 1'b1)
		aw(16'hE124, 8'h11);
		`CK(seen, 1'b0)
		repeat (1260) @(posedge clk_sys);
		aw(16'hE13E, 8'h5A);
		`CK({seen, opAddr, opData}, {1'b1, 16'hE13E, 8'h5A})
		aw(16'hE140, 8'h00);
		`CK(seen, 1'b0)
		drop;
		$display("test program done");
		apb(1, `FPE_OFS_PROTECT, 32'h71);
		arm(4'h2, 16'hE040, 0);
		drop;
		arm(4'h2, 16'hDC00, 1);
		`CK(doPageErase, 1'b1)
		drop;
		arm(4'h6, 16'hDC00, 0);
		drop;
		apb(1, `FPE_OFS_PROTECT, 32'hFF);
		arm(4'h6, 16'hDC00, 1);
		`CK({doMassErase, doPageErase}, 2'b10)
		rstn <= 0;
		@(posedge clk_sys);
		rstn <= 1;
		@(posedge clk_sys);
		rdc(`FPE_OFS_CTRL, 32'hF, 32'h0);
		`CK({pumpOn, doMassErase}, 2'b00)
		drop;
		$display("test protect and mass erase done");
		endOfTest;
	end
endmodule

bind fpe_flash_ctrl fpe_flash_ctrl_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk_sys(clk_sys),
	.rstn(rstn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.arrayWrite(arrayWrite), .arrayAddr(arrayAddr), .arrayWdata(arrayWdata),
	.pumpOn(pumpOn), .doProgram(doProgram), .doPageErase(doPageErase),
	.doMassErase(doMassErase), .opAddr(opAddr), .opData(opData), .opStrobe(opStrobe));
